// ### design/arr_result_regs.sv
/*
 * Measurement result readout registers: battery voltage low byte,
 * signed battery current pair and connector temperature-sense high byte.
 * Assumes the serial management port decoder presents one byte read
 * per rd_en_i pulse and that converter inputs are synchronous to clock_i.
 */
module arr_result_regs
  import arr_pkg::*;
#(
  parameter int FRAC_BITS = ARR_TEMP_FRAC_BITS
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic reg_rst_i,
  input wire logic conv_valid_i,
  input wire logic [15:0] batt_voltage_i,
  input wire logic [15:0] battery_current_result_i,
  input wire logic [15:0] tsbus_pin_mv_i,
  input wire logic [15:0] charger_output_voltage_i,
  input wire logic rd_en_i,
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic temp_busy_o
);

  localparam int DIVIDEND_W = ARR_MAG_BITS + FRAC_BITS + 1;
  localparam int CNT_W = $clog2(DIVIDEND_W + 1);

  if (FRAC_BITS < 1 || FRAC_BITS > 16) begin : g_bad_frac
    $error("FRAC_BITS out of range");
  end

  // ---------------------------------------------------------------
  // Result storage
  // ---------------------------------------------------------------
  logic [15:0] batt_voltage_ff, nxt_batt_voltage;
  logic [15:0] batt_current_ff, nxt_batt_current;
  logic [15:0] connector_temp_result_ff, nxt_connector_temp_result;
  logic [7:0] current_low_shadow_ff, nxt_current_low_shadow;
  logic shadow_valid_ff, nxt_shadow_valid;

  // ---------------------------------------------------------------
  // Ratio divider state
  // ---------------------------------------------------------------
  arr_div_state_t div_state_ff, nxt_div_state;
  logic [DIVIDEND_W-1:0] dividend_ff, nxt_dividend;
  logic [DIVIDEND_W-1:0] quotient_ff, nxt_quotient;
  logic [16:0] remainder_ff, nxt_remainder;
  logic [14:0] divisor_ff, nxt_divisor;
  logic [CNT_W-1:0] div_cnt_ff, nxt_div_cnt;
  logic neg_ff, nxt_neg;
  logic temp_busy_ff, nxt_temp_busy;

  logic [15:0] pin_mag;
  logic [16:0] rem_shift;
  logic [14:0] q_mag;

  // ---------------------------------------------------------------
  // Read port state
  // ---------------------------------------------------------------
  logic [7:0] rd_data_ff, nxt_rd_data;
  logic rd_valid_ff, nxt_rd_valid;

  assign pin_mag = tsbus_pin_mv_i[ARR_SIGN_BIT] ? 16'(-tsbus_pin_mv_i) : tsbus_pin_mv_i;
  assign rem_shift = {remainder_ff[15:0], dividend_ff[DIVIDEND_W-1]};
  assign q_mag = (|quotient_ff[DIVIDEND_W-1:ARR_MAG_BITS]) ? ARR_MAG_SATURATE
                                                          : quotient_ff[ARR_MAG_BITS-1:0];

  // ---------------------------------------------------------------
  // Result capture
  // ---------------------------------------------------------------
  always_comb begin
    nxt_batt_voltage = batt_voltage_ff;
    nxt_batt_current = batt_current_ff;
    nxt_connector_temp_result = connector_temp_result_ff;
    if (conv_valid_i) begin
      nxt_batt_voltage = batt_voltage_i;
      // Sign comes straight from the converter: charge flows in as positive
      nxt_batt_current = battery_current_result_i; // [R2] [R3]
    end
    if (div_state_ff == ARR_DIV_DONE) begin
      // Negative pin voltage with a nonzero q_mag yields a two's complement ratio with bit 15 set
      nxt_connector_temp_result = neg_ff ? 16'(-{1'b0, q_mag}) : {1'b0, q_mag}; // [R3] [R5]
    end
    if (reg_rst_i) begin
      nxt_batt_voltage = ARR_RESULT_RESET; // [R1]
      nxt_batt_current = ARR_RESULT_RESET; // [R1]
      nxt_connector_temp_result = ARR_RESULT_RESET; // [R1]
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      batt_voltage_ff <= ARR_RESULT_RESET;
      batt_current_ff <= ARR_RESULT_RESET;
      connector_temp_result_ff <= ARR_RESULT_RESET;
    end else begin
      batt_voltage_ff <= nxt_batt_voltage;
      batt_current_ff <= nxt_batt_current;
      connector_temp_result_ff <= nxt_connector_temp_result;
    end
  end

  // ---------------------------------------------------------------
  // Connector ratio: (pin << FRAC_BITS) / output voltage
  // ---------------------------------------------------------------
  // A new sample arriving mid-division is dropped; the old ratio stays
  // until the running one finishes, which avoids half-updated results.
  always_comb begin
    nxt_div_state = div_state_ff;
    nxt_dividend = dividend_ff;
    nxt_quotient = quotient_ff;
    nxt_remainder = remainder_ff;
    nxt_divisor = divisor_ff;
    nxt_div_cnt = div_cnt_ff;
    nxt_neg = neg_ff;
    case (div_state_ff)
      ARR_DIV_IDLE: begin
        if (conv_valid_i) begin
          nxt_dividend = DIVIDEND_W'({pin_mag, FRAC_BITS'(0)}); // [R4]
          nxt_divisor = charger_output_voltage_i[ARR_SIGN_BIT] ? 15'h0000
                                                               : charger_output_voltage_i[14:0];
          nxt_neg = tsbus_pin_mv_i[ARR_SIGN_BIT];
          nxt_quotient = '0;
          nxt_remainder = '0;
          nxt_div_cnt = CNT_W'(DIVIDEND_W);
          nxt_div_state = ARR_DIV_RUN;
        end
      end
      ARR_DIV_RUN: begin
        nxt_dividend = {dividend_ff[DIVIDEND_W-2:0], 1'b0};
        if (divisor_ff == 15'h0000) begin
          // No output voltage: report full scale rather than divide by zero
          nxt_quotient = '1;
          nxt_div_state = ARR_DIV_DONE;
        end else begin
          if (rem_shift >= {2'b00, divisor_ff}) begin
            nxt_remainder = rem_shift - {2'b00, divisor_ff};
            nxt_quotient = {quotient_ff[DIVIDEND_W-2:0], 1'b1};
          end else begin
            nxt_remainder = rem_shift;
            nxt_quotient = {quotient_ff[DIVIDEND_W-2:0], 1'b0};
          end
          nxt_div_cnt = div_cnt_ff - CNT_W'(1);
          if (div_cnt_ff == CNT_W'(1)) begin
            nxt_div_state = ARR_DIV_DONE;
          end
        end
      end
      ARR_DIV_DONE: begin
        nxt_div_state = ARR_DIV_IDLE;
      end
      default: begin
        nxt_div_state = ARR_DIV_IDLE;
      end
    endcase
    if (reg_rst_i) begin
      nxt_div_state = ARR_DIV_IDLE; // [R1]
    end
    // Busy is registered so that every output of the block leaves from a flop
    nxt_temp_busy = (nxt_div_state != ARR_DIV_IDLE);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      div_state_ff <= ARR_DIV_IDLE;
      dividend_ff <= '0;
      quotient_ff <= '0;
      remainder_ff <= '0;
      divisor_ff <= '0;
      div_cnt_ff <= '0;
      neg_ff <= 1'b0;
      temp_busy_ff <= 1'b0;
    end else begin
      div_state_ff <= nxt_div_state;
      dividend_ff <= nxt_dividend;
      quotient_ff <= nxt_quotient;
      remainder_ff <= nxt_remainder;
      divisor_ff <= nxt_divisor;
      div_cnt_ff <= nxt_div_cnt;
      neg_ff <= nxt_neg;
      temp_busy_ff <= nxt_temp_busy;
    end
  end

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  // Reading the current high byte freezes its low byte so a back to
  // back low read pairs with the same sample even if a new one lands.
  always_comb begin
    nxt_rd_data = rd_data_ff;
    nxt_rd_valid = rd_en_i;
    nxt_current_low_shadow = current_low_shadow_ff;
    nxt_shadow_valid = shadow_valid_ff;
    if (rd_en_i) begin
      nxt_shadow_valid = 1'b0;
      case (rd_addr_i)
        ARR_BATT_VOLTAGE_LOW_OFS: begin
          nxt_rd_data = batt_voltage_ff[7:0];
        end
        ARR_BATT_CURRENT_HIGH_OFS: begin
          nxt_rd_data = batt_current_ff[15:8]; // [R3]
          nxt_current_low_shadow = batt_current_ff[7:0]; // [R6]
          nxt_shadow_valid = 1'b1;
        end
        ARR_BATT_CURRENT_LOW_OFS: begin
          nxt_rd_data = shadow_valid_ff ? current_low_shadow_ff : batt_current_ff[7:0]; // [R6]
        end
        ARR_BUS_TEMP_SENSE_HIGH_OFS: begin
          nxt_rd_data = connector_temp_result_ff[15:8]; // [R3] [R4]
        end
        default: begin
          nxt_rd_data = ARR_UNMAPPED_DATA;
        end
      endcase
    end
    if (reg_rst_i) begin
      nxt_shadow_valid = 1'b0; // [R1]
      nxt_current_low_shadow = ARR_RESULT_RESET[7:0];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_ff <= ARR_UNMAPPED_DATA;
      rd_valid_ff <= 1'b0;
      current_low_shadow_ff <= ARR_RESULT_RESET[7:0];
      shadow_valid_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      current_low_shadow_ff <= nxt_current_low_shadow;
      shadow_valid_ff <= nxt_shadow_valid;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // There is no write path at all: the fields are read-only. [R1]
  assign rd_data_o = rd_data_ff;
  assign rd_valid_o = rd_valid_ff;
  assign temp_busy_o = temp_busy_ff;

endmodule : arr_result_regs

// ### include/arr_pkg.sv
/*
 * Constants for the charger measurement result readout registers.
 * Assumes an 8-bit register address space reached over the serial
 * management port and a converter that delivers raw results.
 */
// Summary of operation
// [R1] All result fields are read-only and clear to their reset state on a software register reset.
// [R2] Battery current is reported signed: positive while charging, negative while discharging.
// [R3] Bit 7 of each high result byte is the two's complement sign: 0 positive, 1 negative.
// [R4] The connector temperature result is the sense pin voltage as a fraction of output voltage.
// [R5] Each count of the connector temperature result is a fixed 0.09766% step of output voltage.
// [R6] Software reads the high and low bytes of a channel back to back and joins them into 16 bits.
package arr_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ARR_BATT_VOLTAGE_LOW_OFS = 8'h1f;
  localparam logic [7:0] ARR_BATT_CURRENT_HIGH_OFS = 8'h20;
  localparam logic [7:0] ARR_BATT_CURRENT_LOW_OFS = 8'h21;
  localparam logic [7:0] ARR_BUS_TEMP_SENSE_HIGH_OFS = 8'h22;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int ARR_SIGN_BIT = 15;
  localparam int ARR_MAG_BITS = 15;
  localparam logic [15:0] ARR_RESULT_RESET = 16'h0000;
  localparam logic [7:0] ARR_UNMAPPED_DATA = 8'h00;
  localparam logic [14:0] ARR_MAG_SATURATE = 15'h7fff;

  // ---------------------------------------------------------------
  // Ratio scaling: 1024 counts = 100 % of output voltage
  // ---------------------------------------------------------------
  localparam real ARR_TEMP_STEP_PCT = 0.09766;
  localparam int ARR_TEMP_FRAC_BITS = 10;

  typedef enum logic [1:0] {
    ARR_DIV_IDLE,
    ARR_DIV_RUN,
    ARR_DIV_DONE
  } arr_div_state_t;

endpackage : arr_pkg

// ### verif/arr_result_regs_props.sv
/* Concurrent checks on the result readout registers.
   Sees only the ports of arr_result_regs; attached by the bind below. */
module arr_result_regs_props
  import arr_pkg::*;
#(
  parameter int FRAC_BITS = ARR_TEMP_FRAC_BITS
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic reg_rst_i,
  input wire logic conv_valid_i,
  input wire logic [15:0] batt_voltage_i,
  input wire logic [15:0] battery_current_result_i,
  input wire logic [15:0] tsbus_pin_mv_i,
  input wire logic [15:0] charger_output_voltage_i,
  input wire logic rd_en_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic temp_busy_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  property p_answer; rd_en_i |=> rd_valid_o; endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_no_spurious; !rd_en_i |=> !rd_valid_o; endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without read");
  property p_hold; !rd_valid_o |-> $stable(rd_data_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_unmapped;
    rd_en_i && !(rd_addr_i inside {[8'h1f:8'h22]}) |=> rd_data_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // Reads right after a register reset see cleared fields
  property p_regrst;
    reg_rst_i ##1 (rd_en_i && !conv_valid_i && !reg_rst_i) |=> rd_data_o == 8'h00;
  endproperty
  a_regrst: assert property (p_regrst) else $error("field survived register reset");
  property p_cur_high;
    conv_valid_i && !reg_rst_i ##1 (rd_en_i && rd_addr_i == ARR_BATT_CURRENT_HIGH_OFS &&
      !conv_valid_i && !reg_rst_i) |=> rd_data_o == $past(battery_current_result_i[15:8], 2);
  endproperty
  a_cur_high: assert property (p_cur_high) else $error("current high byte wrong");
  // ---------------------------------------------------------------
  // Ratio divider
  // ---------------------------------------------------------------
  property p_busy_start;
    conv_valid_i && !temp_busy_o && !reg_rst_i && $signed(charger_output_voltage_i) > 0
      |=> temp_busy_o;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("ratio did not start");
  property p_busy_span;
    disable iff (rst_i || reg_rst_i)
    $rose(temp_busy_o) && $signed($past(charger_output_voltage_i)) > 0
      |-> ##26 temp_busy_o ##1 !temp_busy_o;
  endproperty
  a_busy_span: assert property (p_busy_span) else $error("ratio run length wrong");
endmodule : arr_result_regs_props

bind arr_result_regs arr_result_regs_props #(.FRAC_BITS(FRAC_BITS)) u_props (.*);

// ### verif/arr_result_regs_test.sv
/* Self-checking bench for the result readout registers.
   Drives every port itself; expects the one-cycle read answer of the port. */
module arr_result_regs_test
  import arr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FB = ARR_TEMP_FRAC_BITS;
  logic clock_i, rst_i, reg_rst_i, conv_valid_i, rd_en_i, rd_valid_o, temp_busy_o;
  logic [15:0] batt_voltage_i, battery_current_result_i, tsbus_pin_mv_i;
  logic [15:0] charger_output_voltage_i;
  logic [7:0] rd_addr_i, rd_data_o;
  int num_errors, compares;
  logic [7:0] addrs [7] = '{8'h1f, 8'h20, 8'h21, 8'h22, 8'h00, 8'h23, 8'hff};
  // Charging, discharging with negative pin, zero divisor, just under full scale
  int tv [4] = '{16'h0f3c, 16'h1234, 16'h00ff, 16'h8001};
  int tc [4] = '{16'h1388, 16'hfc18, 16'h8000, 16'h7fff};
  int tp [4] = '{1000, -1000, 500, 3999};
  int to [4] = '{4000, 4000, 0, 4000};

  arr_result_regs #(.FRAC_BITS(FB)) u_dut (.*);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    rd_en_i <= 1'b1;
    rd_addr_i <= a;
    @(posedge clock_i);
    rd_en_i <= 1'b0;
    #1;
    check({7'h00, rd_valid_o}, 8'h01);
    check(rd_data_o, exp);
  endtask : rd
  // Expected ratio high byte; a zero divisor saturates like an overflow
  function automatic logic [7:0] ratio_hi(input int p, input int o);
    int r;
    r = (o > 0) ? ((p < 0 ? -p : p) * (1 << FB)) / o : 32767;
    r = (r > 32767) ? 32767 : r;
    r = (p < 0) ? -r : r;
    return r[15:8];
  endfunction : ratio_hi
  task automatic sample(input int i);
    int n;
    @(posedge clock_i);
    conv_valid_i <= 1'b1;
    batt_voltage_i <= 16'(tv[i]);
    battery_current_result_i <= 16'(tc[i]);
    tsbus_pin_mv_i <= 16'(tp[i]);
    charger_output_voltage_i <= 16'(to[i]);
    @(posedge clock_i);
    conv_valid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (temp_busy_o !== 1'b0 && n < 40);
    if (n >= 40) begin
      num_errors++;
      complete_run();
    end
  endtask : sample

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  initial begin
    {rst_i, reg_rst_i, conv_valid_i, rd_en_i, rd_addr_i} = {1'b1, 3'b000, 8'h00};
    {batt_voltage_i, battery_current_result_i} = 32'h0000_0000;
    {tsbus_pin_mv_i, charger_output_voltage_i} = 32'h0000_0000;
    num_errors = 0;
    compares = 0;
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    for (int i = 0; i < 4; i++) begin
      sample(i);
      rd(8'h1f, tv[i][7:0]);
      rd(8'h20, tc[i][15:8]);
      rd(8'h21, tc[i][7:0]);
      rd(8'h22, ratio_hi(tp[i], to[i]));
    end
    // A sample landing on the same edge as the low read of a paired high and low read must not split them
    @(posedge clock_i);
    conv_valid_i <= 1'b1;
    battery_current_result_i <= 16'h1357;
    @(posedge clock_i);
    conv_valid_i <= 1'b0;
    rd_en_i <= 1'b1;
    rd_addr_i <= 8'h20;
    @(posedge clock_i);
    conv_valid_i <= 1'b1;
    battery_current_result_i <= 16'h2468;
    rd_addr_i <= 8'h21;
    #1;
    check(rd_data_o, 8'h13);
    @(posedge clock_i);
    conv_valid_i <= 1'b0;
    rd_en_i <= 1'b0;
    #1;
    check(rd_data_o, 8'h57);
    rd(8'h21, 8'h68);
    rd(8'h20, 8'h24);
    repeat (30) @(posedge clock_i);
    // Register reset in the middle of a ratio run must abort it too
    @(posedge clock_i);
    conv_valid_i <= 1'b1;
    @(posedge clock_i);
    conv_valid_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    reg_rst_i <= 1'b1;
    @(posedge clock_i);
    reg_rst_i <= 1'b0;
    rd_en_i <= 1'b1;
    rd_addr_i <= 8'h20;
    @(posedge clock_i);
    rd_en_i <= 1'b0;
    #1;
    check(rd_data_o, 8'h00);
    repeat (30) @(posedge clock_i);
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    complete_run();
  end
endmodule : arr_result_regs_test
